// ---- design/pevi_incr.v ----
// Purpose: event selection and per-clock increment for perf counters
// Assumes: all event inputs come from core logic on core_clk_in
// Notes: incr_out and count_out update on the edge after the event
//
// Functional notes
// - code 16H adds completed instructions, 0 to 2
// - fault handlers, interrupts, exceptions count as instructions
// - repeated string instruction adds exactly one
// - each halt instruction adds exactly one
// - code 17H counts second pipe instructions only
// - code 18H counts every busy bus clock
// - code 19H counts full write buffer stall clocks
// - code 19H excludes stalls from I/O accesses
// - code 1AH counts data read wait clocks
// - code 1BH counts each E/M line write stall
// - code 1CH counts locked bus cycles
// - locked read-modify-write counts only its read
// - split locked cycle counts as two
// - back-off restarted cycles are not recounted
// - code 1DH counts each I/O bus cycle
// - code 1EH counts noncacheable non-I/O reads
// - code 1FH counts interlocks, two if both pipes
// - interlock: execute writes address-stage base/index
`timescale 1ns/1ps
`include "pevi_map.vh"

module pevi_incr #(
   parameter CNT_W = 40
) (
   input wire core_clk_in,
   input wire resetn_in,
   // selection and counter control
   input wire [`PEVI_SEL_W-1:0] evt_sel_in,
   input wire count_en_in,
   input wire count_clr_in,
   // instruction completion
   input wire u_retire_in,
   input wire v_retire_in,
   input wire fault_entry_in,
   input wire intr_entry_in,
   input wire rep_iter_in,
   input wire rep_last_in,
   input wire halt_instr_in,
   // bus unit
   input wire bus_busy_in,
   input wire hold_ack_in,
   input wire addr_hold_in,
   input wire backoff_n_in,
   input wire bus_start_in,
   input wire bus_write_in,
   input wire bus_locked_in,
   input wire bus_io_in,
   input wire bus_cacheable_in,
   input wire split_cycle_ind_in,
   // pipeline stalls
   input wire wbuf_full_stall_in,
   input wire stall_io_in,
   input wire dread_stall_in,
   input wire dtlb_miss_busy_in,
   input wire em_write_stall_in,
   // execute stage destination, per pipe
   input wire u_ex_wr_in,
   input wire [`PEVI_REG_W-1:0] u_ex_reg_in,
   input wire v_ex_wr_in,
   input wire [`PEVI_REG_W-1:0] v_ex_reg_in,
   // address generation stage sources, per pipe
   input wire u_ag_base_vld_in,
   input wire [`PEVI_REG_W-1:0] u_ag_base_in,
   input wire u_ag_idx_vld_in,
   input wire [`PEVI_REG_W-1:0] u_ag_idx_in,
   input wire v_ag_base_vld_in,
   input wire [`PEVI_REG_W-1:0] v_ag_base_in,
   input wire v_ag_idx_vld_in,
   input wire [`PEVI_REG_W-1:0] v_ag_idx_in,
   // results
   output wire [`PEVI_INC_W-1:0] incr_out,
   output wire [CNT_W-1:0] count_out,
   output wire addr_gen_interlock_out
);

////////////////////////////////////////////////////////////////////////
// helpers

// one source register hit by either execute-stage write
function hit;
   input src_vld;
   input [`PEVI_REG_W-1:0] src;
   input uw;
   input [`PEVI_REG_W-1:0] ureg;
   input vw;
   input [`PEVI_REG_W-1:0] vreg;
   begin
      hit = src_vld & ((uw & (ureg == src)) | (vw & (vreg == src)));
   end
endfunction

// clamp a 0..3 sum to the per-clock maximum
function [`PEVI_INC_W-1:0] clamp2;
   input [`PEVI_INC_W-1:0] v;
   begin
      if (v > `PEVI_INC_MAX) begin
         clamp2 = `PEVI_INC_MAX;
      end else begin
         clamp2 = v;
      end
   end
endfunction

////////////////////////////////////////////////////////////////////////
// state

reg rep_busy_r;
reg rep_busy_nxt;
reg halt_d_r;
reg em_stall_d_r;
reg restart_pend_r;
reg restart_pend_nxt;
reg [`PEVI_INC_W-1:0] incr_r;
reg [`PEVI_INC_W-1:0] incr_nxt;
reg [CNT_W-1:0] cnt_r;
reg [CNT_W-1:0] cnt_nxt;
reg interlock_r;

////////////////////////////////////////////////////////////////////////
// instruction events

wire u_rep_step;
wire u_counted;
wire v_counted;
wire exc_counted;
wire halt_counted;
wire [`PEVI_INC_W-1:0] instr_cnt;
wire [`PEVI_INC_W-1:0] vinstr_cnt;

// later iterations of a repeated string add nothing
assign u_rep_step = u_retire_in & rep_iter_in & rep_busy_r;

// halted clocks never look like completions
assign u_counted = u_retire_in & ~u_rep_step & ~halt_instr_in;
assign v_counted = v_retire_in & ~halt_instr_in;

// handler entries count as executed instructions
assign exc_counted = fault_entry_in | intr_entry_in;

// halt counts once, on entry to the halted state
assign halt_counted = halt_instr_in & ~halt_d_r;

assign instr_cnt = clamp2({1'b0, u_counted} + {1'b0, v_counted} +
   {1'b0, exc_counted} + {1'b0, halt_counted});

assign vinstr_cnt = {1'b0, v_counted};

// loop tracking: busy after an iteration that is not the last
always @* begin
   rep_busy_nxt = rep_busy_r;
   if (exc_counted) begin
      rep_busy_nxt = 1'b0;
   end else if (u_retire_in) begin
      rep_busy_nxt = rep_iter_in & ~rep_last_in;
   end
end

////////////////////////////////////////////////////////////////////////
// duration events

wire busclk_evt;
wire wbuf_full_stall_evt;
wire rdstall_evt;
wire emstall_evt;

// hold, address hold and back-off clocks count as busy
assign busclk_evt = bus_busy_in | hold_ack_in | addr_hold_in |
   ~backoff_n_in;

assign wbuf_full_stall_evt = wbuf_full_stall_in & ~stall_io_in;

assign rdstall_evt = dread_stall_in | dtlb_miss_busy_in;

// each stall once, at its first clock
assign emstall_evt = em_write_stall_in & ~em_stall_d_r;

////////////////////////////////////////////////////////////////////////
// bus cycle events

wire first_start;
wire locked_evt;
wire io_evt;
wire ncread_evt;
wire [`PEVI_INC_W-1:0] locked_cnt;

// a cycle aborted by back-off is restarted later
always @* begin
   restart_pend_nxt = restart_pend_r;
   if (~backoff_n_in & bus_busy_in) begin
      restart_pend_nxt = 1'b1;
   end else if (bus_start_in) begin
      restart_pend_nxt = 1'b0;
   end
end

assign first_start = bus_start_in & ~restart_pend_r;

// read half of a locked sequence only
assign locked_evt = first_start & bus_locked_in &
   ~bus_write_in;

// split locked access counts as two accesses
assign locked_cnt = ~locked_evt ? `PEVI_INC_ZERO :
   (split_cycle_ind_in ? `PEVI_INC_MAX : 2'h1);

// each bus cycle of a misaligned access strobes separately
assign io_evt = first_start & bus_io_in;

assign ncread_evt = first_start & ~bus_write_in &
   ~bus_cacheable_in & ~bus_io_in;

////////////////////////////////////////////////////////////////////////
// address generation interlock

wire u_interlock;
wire v_interlock;
wire [`PEVI_INC_W-1:0] interlock_cnt;

assign u_interlock = hit(u_ag_base_vld_in, u_ag_base_in, u_ex_wr_in,
   u_ex_reg_in, v_ex_wr_in, v_ex_reg_in) |
   hit(u_ag_idx_vld_in, u_ag_idx_in, u_ex_wr_in,
   u_ex_reg_in, v_ex_wr_in, v_ex_reg_in);

assign v_interlock = hit(v_ag_base_vld_in, v_ag_base_in, u_ex_wr_in,
   u_ex_reg_in, v_ex_wr_in, v_ex_reg_in) |
   hit(v_ag_idx_vld_in, v_ag_idx_in, u_ex_wr_in,
   u_ex_reg_in, v_ex_wr_in, v_ex_reg_in);

// both pipes in one clock add two
assign interlock_cnt = {1'b0, u_interlock} + {1'b0, v_interlock};

////////////////////////////////////////////////////////////////////////
// selection

always @* begin
   incr_nxt = `PEVI_INC_ZERO;
   case (evt_sel_in)
      `PEVI_EVT_INSTR: begin
         incr_nxt = instr_cnt;
      end
      `PEVI_EVT_VINSTR: begin
         incr_nxt = vinstr_cnt;
      end
      `PEVI_EVT_BUSCLK: begin
         incr_nxt = {1'b0, busclk_evt};
      end
      `PEVI_EVT_WBSTALL: begin
         incr_nxt = {1'b0, wbuf_full_stall_evt};
      end
      `PEVI_EVT_RDSTALL: begin
         incr_nxt = {1'b0, rdstall_evt};
      end
      `PEVI_EVT_EMSTALL: begin
         incr_nxt = {1'b0, emstall_evt};
      end
      `PEVI_EVT_LOCKED: begin
         incr_nxt = locked_cnt;
      end
      `PEVI_EVT_IOCYC: begin
         incr_nxt = {1'b0, io_evt};
      end
      `PEVI_EVT_NCREAD: begin
         incr_nxt = {1'b0, ncread_evt};
      end
      `PEVI_EVT_INTERLOCK: begin
         incr_nxt = interlock_cnt;
      end
      `PEVI_EVT_RSV0, `PEVI_EVT_RSV1: begin
         incr_nxt = `PEVI_INC_ZERO;
      end
      default: begin
         incr_nxt = `PEVI_INC_ZERO;
      end
   endcase
   if (~count_en_in) begin
      incr_nxt = `PEVI_INC_ZERO;
   end
end

////////////////////////////////////////////////////////////////////////
// counter

always @* begin
   if (count_clr_in) begin
      cnt_nxt = {CNT_W{1'b0}};
   end else begin
      cnt_nxt = cnt_r + {{(CNT_W-`PEVI_INC_W){1'b0}}, incr_nxt};
   end
end

////////////////////////////////////////////////////////////////////////
// registers

always @(posedge core_clk_in or negedge resetn_in) begin
   if (~resetn_in) begin
      rep_busy_r <= `PEVI_RST_FLAG;
      halt_d_r <= `PEVI_RST_FLAG;
      em_stall_d_r <= `PEVI_RST_FLAG;
      restart_pend_r <= `PEVI_RST_FLAG;
      interlock_r <= `PEVI_RST_FLAG;
      incr_r <= `PEVI_RST_INC;
      cnt_r <= {CNT_W{1'b0}};
   end else begin
      rep_busy_r <= rep_busy_nxt;
      halt_d_r <= halt_instr_in;
      em_stall_d_r <= em_write_stall_in;
      restart_pend_r <= restart_pend_nxt;
      interlock_r <= u_interlock | v_interlock;
      incr_r <= incr_nxt;
      cnt_r <= cnt_nxt;
   end
end

assign incr_out = incr_r;
assign count_out = cnt_r;
assign addr_gen_interlock_out = interlock_r;

endmodule

// ---- design/pevi_map.vh ----
// Purpose: constants for the event increment logic
// Assumes: included by bare name
// Notes: event codes, widths and reset values
`ifndef PEVI_MAP_VH
`define PEVI_MAP_VH

// event select width and codes
`define PEVI_SEL_W 6
`define PEVI_EVT_INSTR 6'h16
`define PEVI_EVT_VINSTR 6'h17
`define PEVI_EVT_BUSCLK 6'h18
`define PEVI_EVT_WBSTALL 6'h19
`define PEVI_EVT_RDSTALL 6'h1A
`define PEVI_EVT_EMSTALL 6'h1B
`define PEVI_EVT_LOCKED 6'h1C
`define PEVI_EVT_IOCYC 6'h1D
`define PEVI_EVT_NCREAD 6'h1E
`define PEVI_EVT_INTERLOCK 6'h1F
`define PEVI_EVT_RSV0 6'h20
`define PEVI_EVT_RSV1 6'h21

// per-clock increment
`define PEVI_INC_W 2
`define PEVI_INC_MAX 2'h2
`define PEVI_INC_ZERO 2'h0

// register number field
`define PEVI_REG_W 3

// reset values
`define PEVI_RST_INC 2'h0
`define PEVI_RST_FLAG 1'h0

`endif

// ---- sim/pevi_core_model.sv ----
// Purpose: core pipeline and bus unit stand-in
// Assumes: rnd_in is redrawn on every clock
// Notes: keeps qualifiers legal, all quiet in reset
`timescale 1ns/1ps
module pevi_core_model (
   input wire resetn_in,
   input wire [63:0] rnd_in,
   output logic [45:0] ev_out
);
   logic [63:0] r;
   logic hl, u, ri, bk;
   always_comb begin
      r = resetn_in ? rnd_in : 64'h0;
      hl = &r[1:0];
      // nothing completes while halted
      u = r[2] & !hl;
      ri = u & r[3];
      bk = !(r[12] & r[13]);
      // no new cycle starts under back-off
      ev_out = {hl, u, ri, ri & r[4], r[5] & !hl,
         !hl & (r[7:6] == 2'h3), !hl & (r[7:6] == 2'h1),
         r[9], r[10] & r[43], r[11] & r[44], bk, bk & r[14],
         r[18:15], r[17] & r[19], r[24:20],
         r[25], 1'b0, r[27:26], r[28], 1'b0, r[30:29],
         r[31], 1'b0, r[33:32], r[34], 1'b0, r[36:35],
         r[37], 1'b0, r[39:38], r[40], 1'b0, r[42:41]};
   end
endmodule

// ---- sim/pevi_incr_sva.sv ----
// Purpose: temporal checks on the event increment logic
// Assumes: bound to every pevi_incr instance
// Notes: one clock from inputs to incr_out
`timescale 1ns/1ps
`include "pevi_map.vh"
module pevi_incr_sva #(
   parameter CNT_W = 40
) (
   input wire core_clk_in,
   input wire resetn_in,
   input wire [`PEVI_SEL_W-1:0] evt_sel_in,
   input wire count_en_in,
   input wire count_clr_in,
   input wire v_retire_in,
   input wire fault_entry_in,
   input wire intr_entry_in,
   input wire halt_instr_in,
   input wire bus_busy_in,
   input wire hold_ack_in,
   input wire addr_hold_in,
   input wire backoff_n_in,
   input wire wbuf_full_stall_in,
   input wire stall_io_in,
   input wire [`PEVI_INC_W-1:0] incr_out,
   input wire [CNT_W-1:0] count_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!resetn_in);
   sequence s_halted;
      halt_instr_in [*2];
   endsequence
   sequence s_sel(logic [5:0] c);
      evt_sel_in == c && count_en_in;
   endsequence
   a_rsv_idle: assert property (
      evt_sel_in inside {`PEVI_EVT_RSV0, `PEVI_EVT_RSV1} |=> incr_out == 2'h0)
      else $error("reserved code advanced");
   a_en_gate: assert property (
      !count_en_in |=> incr_out == 2'h0) else $error("disabled but advanced");
   a_cnt_adds: assert property (
      !count_clr_in |=> count_out == $past(count_out) + incr_out)
      else $error("count step wrong");
   a_clr_zero: assert property (
      count_clr_in |=> count_out == 0) else $error("clear missed");
   a_vpipe_only: assert property (
      s_sel(`PEVI_EVT_VINSTR) ##0 !(fault_entry_in || intr_entry_in)
      ##0 !halt_instr_in |=> incr_out == {1'b0, $past(v_retire_in)})
      else $error("second pipe count wrong");
   a_bus_clocks: assert property (
      s_sel(`PEVI_EVT_BUSCLK) |=> incr_out == {1'b0,
      $past(bus_busy_in || hold_ack_in || addr_hold_in || !backoff_n_in)})
      else $error("bus clock count wrong");
   a_wbuf_noio: assert property (
      s_sel(`PEVI_EVT_WBSTALL)
      |=> incr_out == {1'b0, $past(wbuf_full_stall_in && !stall_io_in)})
      else $error("write buffer stall wrong");
   a_halt_once: assert property (
      s_halted ##0 s_sel(`PEVI_EVT_INSTR) ##0 !fault_entry_in
      ##0 !intr_entry_in |=> incr_out == 2'h0) else $error("halt recounted");
endmodule
bind pevi_incr pevi_incr_sva #(.CNT_W(CNT_W)) i_pevi_incr_sva (
   .core_clk_in, .resetn_in, .evt_sel_in, .count_en_in, .count_clr_in,
   .v_retire_in, .fault_entry_in, .intr_entry_in, .halt_instr_in,
   .bus_busy_in, .hold_ack_in, .addr_hold_in, .backoff_n_in,
   .wbuf_full_stall_in, .stall_io_in,
   .incr_out, .count_out);

// ---- sim/pevi_incr_tb.sv ----
// Purpose: self-checking bench for the event increment logic
// Assumes: partner model supplies legal core activity
// Notes: reference model is updated on every clock
`timescale 1ns/1ps
`include "pevi_map.vh"
module pevi_incr_tb;
   logic core_clk_in, resetn_in, count_en_in, count_clr_in;
   logic [`PEVI_SEL_W-1:0] evt_sel_in;
   logic halt_instr_in, u_retire_in, rep_iter_in, rep_last_in;
   logic v_retire_in, fault_entry_in, intr_entry_in, bus_busy_in;
   logic hold_ack_in, addr_hold_in, backoff_n_in, bus_start_in;
   logic bus_write_in, bus_locked_in, bus_io_in, bus_cacheable_in;
   logic split_cycle_ind_in, wbuf_full_stall_in, stall_io_in;
   logic dread_stall_in, dtlb_miss_busy_in, em_write_stall_in;
   logic u_ex_wr_in, v_ex_wr_in, u_ag_base_vld_in, u_ag_idx_vld_in;
   logic v_ag_base_vld_in, v_ag_idx_vld_in;
   logic [2:0] u_ex_reg_in, v_ex_reg_in, u_ag_base_in, u_ag_idx_in;
   logic [2:0] v_ag_base_in, v_ag_idx_in;
   logic [`PEVI_INC_W-1:0] incr_out, ei;
   logic [39:0] count_out, ec;
   logic addr_gen_interlock_out, rb, hp, ep, rp, ea, st, ua, va;
   logic [63:0] rnd;
   logic [45:0] ev;
   int e, err_total, checked;
   assign {halt_instr_in, u_retire_in, rep_iter_in, rep_last_in,
      v_retire_in, fault_entry_in, intr_entry_in, bus_busy_in, hold_ack_in,
      addr_hold_in, backoff_n_in, bus_start_in, bus_write_in, bus_locked_in,
      bus_io_in, bus_cacheable_in, split_cycle_ind_in, wbuf_full_stall_in,
      stall_io_in, dread_stall_in, dtlb_miss_busy_in, em_write_stall_in,
      u_ex_wr_in, u_ex_reg_in, v_ex_wr_in, v_ex_reg_in, u_ag_base_vld_in,
      u_ag_base_in, u_ag_idx_vld_in, u_ag_idx_in, v_ag_base_vld_in,
      v_ag_base_in, v_ag_idx_vld_in, v_ag_idx_in} = ev;
   pevi_core_model i_pevi_core_model (.resetn_in(resetn_in), .rnd_in(rnd),
      .ev_out(ev));
   pevi_incr i_pevi_incr (.*);
   initial begin
      core_clk_in = 1'b0;
      forever #12.5 core_clk_in = ~core_clk_in;
   end
   function automatic logic hit(input logic vl, input logic [2:0] s);
      return vl && (u_ex_wr_in && u_ex_reg_in == s
         || v_ex_wr_in && v_ex_reg_in == s);
   endfunction
   ////////////////////////////////////////////////////////////////////////
   always @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         {rb, hp, ep, rp, ea} <= 5'h0;
         ei <= 2'h0;
         ec <= 40'h0;
      end else begin
         st = bus_start_in && !rp;
         ua = hit(u_ag_base_vld_in, u_ag_base_in)
            || hit(u_ag_idx_vld_in, u_ag_idx_in);
         va = hit(v_ag_base_vld_in, v_ag_base_in)
            || hit(v_ag_idx_vld_in, v_ag_idx_in);
         case (evt_sel_in)
            `PEVI_EVT_INSTR: e = (u_retire_in && !(rep_iter_in && rb))
               + v_retire_in + (fault_entry_in || intr_entry_in)
               + (halt_instr_in && !hp);
            `PEVI_EVT_VINSTR: e = v_retire_in;
            `PEVI_EVT_BUSCLK: e = bus_busy_in || hold_ack_in
               || addr_hold_in || !backoff_n_in;
            `PEVI_EVT_WBSTALL: e = wbuf_full_stall_in
               && !stall_io_in;
            `PEVI_EVT_RDSTALL: e = dread_stall_in || dtlb_miss_busy_in;
            `PEVI_EVT_EMSTALL: e = em_write_stall_in && !ep;
            `PEVI_EVT_LOCKED: e = st && bus_locked_in
               && !bus_write_in ? 1 + split_cycle_ind_in : 0;
            `PEVI_EVT_IOCYC: e = st && bus_io_in;
            `PEVI_EVT_NCREAD: e = st && !bus_cacheable_in
               && !bus_write_in && !bus_io_in;
            `PEVI_EVT_INTERLOCK: e = ua + va;
            default: e = 0;
         endcase
         if (e > 2 || !count_en_in) e = (e > 2 && count_en_in) ? 2 : 0;
         ei <= 2'(e);
         ec <= count_clr_in ? 40'h0 : ec + 40'(e);
         ea <= ua || va;
         // any u-pipe completion ends or continues the loop
         rb <= fault_entry_in || intr_entry_in ? 1'b0
            : u_retire_in ? rep_iter_in && !rep_last_in : rb;
         hp <= halt_instr_in;
         ep <= em_write_stall_in;
         rp <= !backoff_n_in && bus_busy_in ? 1'b1 : bus_start_in ? 1'b0 : rp;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic cmp(input logic [39:0] got, input logic [39:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("FAIL t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cmp_incr(input logic [1:0] got, input logic [1:0] exp);
      cmp(40'(got), 40'(exp));
   endtask
   task automatic cmp_count(input logic [39:0] got, input logic [39:0] exp);
      cmp(got, exp);
   endtask
   task automatic cmp_flag(input logic got, input logic exp);
      cmp(40'(got), 40'(exp));
   endtask
   task automatic run(input logic [5:0] sel, input int n);
      repeat (n) begin
         @(posedge core_clk_in);
         evt_sel_in <= sel;
         rnd <= {$urandom, $urandom};
         count_en_in <= $urandom_range(7) != 0;
         count_clr_in <= $urandom_range(63) == 0;
         @(negedge core_clk_in);
         if (resetn_in) cmp_incr(incr_out, ei);
         if (resetn_in) cmp_count(count_out, ec);
         if (resetn_in) cmp_flag(addr_gen_interlock_out, ea);
      end
      $display("code %h done, %0d checks", sel, checked);
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      {resetn_in, count_en_in, count_clr_in} = 3'h0;
      evt_sel_in = 6'h00;
      rnd = 64'h0;
      err_total = 0;
      checked = 0;
      void'($urandom(44));
      repeat (12) @(posedge core_clk_in);
      resetn_in <= 1'b1;
      for (int k = 6'h15; k <= 6'h22; k++) run(6'(k), 300);
      @(posedge core_clk_in);
      resetn_in <= 1'b0;
      @(posedge core_clk_in);
      resetn_in <= 1'b1;
      run(`PEVI_EVT_LOCKED, 200);
      end_of_test;
   end
   initial begin
      repeat (20000) @(posedge core_clk_in);
      err_total++;
      end_of_test;
   end
endmodule
